// ===== design/kbd_start_stop_tx.sv
// Keyboard start-stop transmitter: key matrix in, marking/spacing line out.
// Key and received-character pins are asynchronous and synchronised here;
// the register port is on mclk.
`timescale 1ns/1ps
`default_nettype none

// Function
// - A pressed key's five-element code is captured; Y marks elements 1,3,5.
// - A captured key starts a transmission cycle at once when idle, else at the end of the current stop element.
// - The five elements are frozen at cycle start.
// - Every frame opens with a spacing start element.
// - Element 1 follows start; marking closes the line, spacing opens it.
// - The stop element is always marking.
// - The keyboard accepts the next key partway through a frame.
// - After a frame with nothing queued the transmitter idles.
// - A held key sends one frame only in normal operation.
// - A key re-arms only after release.
// - Repeat key plus another key sends that code continuously.
// - With space repeat on, a held space sends spaces continuously.
// - Space repeat can be switched off.
// - The lock key sets a lasting lock that blocks every code key.
// - The unlock key clears the lock.
// - Optionally lock on one or two received blank codes.
// - Local return pulses the local printer only, never the line.
// - Several keys at once give exactly one accepted code or none.
// - The idle line stays marking.
module kbd_start_stop_tx
  import kbd_tx_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = kbd_tx_pkg::ELEM_CYCLES
) (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rst,
  // Register port
  input  wire logic [kbd_tx_pkg::ADDR_W-1:0] addr,
  input  wire logic [kbd_tx_pkg::DATA_W-1:0] wrData,
  input  wire logic                          wrStb,
  input  wire logic                          rdStb,
  output logic      [kbd_tx_pkg::DATA_W-1:0] rdData,
  // Key matrix, one line per code
  input  wire logic [kbd_tx_pkg::NKEYS-1:0]  codeKeys,
  input  wire logic                          autoResendKey,
  input  wire logic                          entryBlockKey,
  input  wire logic                          entryReleaseKey,
  input  wire logic                          localReturnKey,
  // Received characters from the local typing unit
  input  wire logic                          rxCharStb,
  input  wire logic                          rxCharBlank,
  // Line and local printer
  output logic                               lineMark,
  output logic                               localReturn
);
  import kbd_tx_pkg::*;

  localparam int SW = NKEYS + 6;
  localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(BIT_CYCLES - 1);

  logic [SW-1:0]     syncA_r;
  logic [SW-1:0]     syncB_r;
  logic [SW-1:0]     syncC_r;
  logic [NKEYS-1:0]  keyS;
  logic              repeatS;
  logic              rxStbRise;
  logic              rxBlankS;
  logic              lockRise;
  logic              unlockS;
  logic              lretRise;

  txst_e             state_r;
  txst_e             state_nxt;
  logic [CNT_W-1:0]  tickCnt_r;
  logic [2:0]        elemIdx_r;
  logic [4:0]        frame_r;
  logic [4:0]        pendCode_r;
  logic              pending_r;
  logic              armed_r;
  logic              locked_r;
  logic              prevBlank_r;
  logic              spaceRep_r;
  logic [1:0]        lockMode_r;
  logic              lineMark_nxt;

  logic              tickEnd;
  logic              launch;
  logic              stopEnd;
  logic              keyOne;
  logic              noKey;
  logic [4:0]        keyIdx;
  logic              kbReady;
  logic              spaceOk;
  logic              accept;
  logic              blankLock;
  logic              lockSet;
  logic              ctrlWr;
  logic [DATA_W-1:0] rdMux;

  // Two-stage synchronisers; third stage only feeds edge detection
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      syncA_r <= '0;
      syncB_r <= '0;
      syncC_r <= '0;
    end else begin
      syncA_r <= {rxCharBlank, rxCharStb, localReturnKey, entryReleaseKey,
                  entryBlockKey, autoResendKey, codeKeys};
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
    end
  end

  assign keyS      = syncB_r[NKEYS-1:0];
  assign repeatS   = syncB_r[NKEYS];
  assign lockRise  = syncB_r[NKEYS+1] & ~syncC_r[NKEYS+1];
  assign unlockS   = syncB_r[NKEYS+2];
  assign lretRise  = syncB_r[NKEYS+3] & ~syncC_r[NKEYS+3];
  assign rxStbRise = syncB_r[NKEYS+4] & ~syncC_r[NKEYS+4];
  assign rxBlankS  = syncB_r[NKEYS+5];

  // Several keys at once are all refused, never merged
  assign noKey  = (keyS == '0);
  assign keyOne = !noKey && ((keyS & (keyS - 1'b1)) == '0);

  always_comb begin
    keyIdx = '0;
    for (int i = 0; i < NKEYS; i++) begin
      if (keyS[i]) begin
        keyIdx = 5'(i);
      end
    end
  end

  // Frame timing
  assign tickEnd = (tickCnt_r == TICK_LAST);
  assign stopEnd = (state_r == ST_STOP) && tickEnd;
  assign launch  = pending_r && ((state_r == ST_IDLE) || stopEnd);

  // Ready from idle, or once past the early part of the frame
  assign kbReady = (state_r == ST_IDLE) || (state_r == ST_STOP) ||
                   ((state_r == ST_DATA) && (elemIdx_r >= READY_ELEM));

  // Space repeat is a switchable option
  assign spaceOk = spaceRep_r && (keyIdx == SPACE_CODE);

  // Held key sends once unless repeat applies
  assign accept = keyOne && !locked_r && !pending_r && kbReady &&
                  (armed_r || repeatS || spaceOk);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:  if (launch) state_nxt = ST_START;
      ST_START: if (tickEnd) state_nxt = ST_DATA;
      ST_DATA:  if (tickEnd && elemIdx_r == LAST_ELEM) state_nxt = ST_STOP;
      ST_STOP: begin
        if (tickEnd) begin
          state_nxt = launch ? ST_START : ST_IDLE;
        end
      end
    endcase
  end

  // Line level follows the next state so it lines up with state_r
  always_comb begin
    unique case (state_nxt)
      ST_IDLE:  lineMark_nxt = 1'b1;
      ST_START: lineMark_nxt = 1'b0;
      ST_STOP:  lineMark_nxt = 1'b1;
      ST_DATA: begin
        if (state_r == ST_START) begin
          lineMark_nxt = frame_r[0];
        end else if (tickEnd) begin
          lineMark_nxt = frame_r[elemIdx_r + 3'h1];
        end else begin
          lineMark_nxt = frame_r[elemIdx_r];
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r   <= ST_IDLE;
      lineMark  <= 1'b1;
      tickCnt_r <= '0;
      elemIdx_r <= '0;
      frame_r   <= '0;
    end else begin
      state_r   <= state_nxt;
      lineMark  <= lineMark_nxt;
      tickCnt_r <= (launch || tickEnd) ? '0 : tickCnt_r + 1'b1;
      if (launch) begin
        frame_r <= pendCode_r;
      end
      if (state_r == ST_DATA && tickEnd) begin
        elemIdx_r <= elemIdx_r + 3'h1;
      end else if (state_r != ST_DATA) begin
        elemIdx_r <= '0;
      end
    end
  end

  // One-slot queue and re-arm after release
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pending_r  <= 1'b0;
      pendCode_r <= '0;
      armed_r    <= 1'b1;
    end else begin
      if (accept) begin
        pending_r  <= 1'b1;
        pendCode_r <= keyIdx;
      end else if (launch) begin
        pending_r  <= 1'b0;
      end
      if (noKey) begin
        armed_r <= 1'b1;
      end else if (accept) begin
        armed_r <= 1'b0;
      end
    end
  end

  // Automatic lock on received blanks
  assign blankLock = rxStbRise && rxBlankS &&
                     ((lockMode_r == LMODE_SINGLE) ||
                      (lockMode_r == LMODE_DOUBLE && prevBlank_r));
  assign lockSet   = lockRise || blankLock;

  // Setting wins over a simultaneous unlock
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      locked_r    <= 1'b0;
      prevBlank_r <= 1'b0;
      localReturn <= 1'b0;
    end else begin
      if (lockSet) begin
        locked_r <= 1'b1;
      end else if (unlockS) begin
        locked_r <= 1'b0;
      end
      if (rxStbRise) begin
        prevBlank_r <= rxBlankS;
      end
      // Local printer only; the line path never sees this key
      localReturn <= lretRise;
    end
  end

  // Register port
  assign ctrlWr = wrStb && (addr == ADDR_CTRL);

  always_comb begin
    rdMux = '0;
    if (addr == ADDR_CTRL) begin
      rdMux[CTRL_SPREP]                = spaceRep_r;
      rdMux[CTRL_LMODE_LO +: 2]        = lockMode_r;
    end else if (addr == ADDR_STATUS) begin
      rdMux[STAT_LOCK]                 = locked_r;
      rdMux[STAT_BUSY]                 = (state_r != ST_IDLE);
      rdMux[STAT_PEND]                 = pending_r;
      rdMux[STAT_CODE_LO +: CODE_W]    = frame_r;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      spaceRep_r <= SPREP_RST;
      lockMode_r <= LMODE_RST;
      rdData     <= '0;
    end else begin
      if (ctrlWr) begin
        spaceRep_r <= wrData[CTRL_SPREP];
        lockMode_r <= wrData[CTRL_LMODE_LO +: 2];
      end
      rdData <= rdStb ? rdMux : '0;
    end
  end

  // Checks
  AST_IDLE_MARK: assert property (@(posedge mclk) disable iff (rst)
    state_r == ST_IDLE |-> lineMark)
    else $error("line not marking while idle");
  AST_START_SPACE: assert property (@(posedge mclk) disable iff (rst)
    $rose(state_r == ST_START) |-> !lineMark [*2])
    else $error("start element not spacing");
  AST_STOP_MARK: assert property (@(posedge mclk) disable iff (rst)
    state_r == ST_STOP |-> lineMark)
    else $error("stop element not marking");
  AST_DATA_BIT: assert property (@(posedge mclk) disable iff (rst)
    state_r == ST_DATA |-> lineMark == frame_r[elemIdx_r])
    else $error("data element differs from frozen code");
  AST_FROZEN: assert property (@(posedge mclk) disable iff (rst)
    state_r == ST_DATA |-> $stable(frame_r))
    else $error("code changed during frame");
  AST_IMMEDIATE: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ST_IDLE && pending_r) |=> state_r == ST_START)
    else $error("captured key did not start a frame");
  AST_BACK2BACK: assert property (@(posedge mclk) disable iff (rst)
    (stopEnd && pending_r) |=> (state_r == ST_START) && (frame_r ==
    $past(pendCode_r)))
    else $error("queued key not sent after stop");
  AST_GO_IDLE: assert property (@(posedge mclk) disable iff (rst)
    (stopEnd && !pending_r) |=> state_r == ST_IDLE)
    else $error("did not idle after frame");
  AST_LOCK_BLOCK: assert property (@(posedge mclk) disable iff (rst)
    locked_r |=> !pending_r || $past(pending_r))
    else $error("key accepted while locked");
  AST_ONE_KEY: assert property (@(posedge mclk) disable iff (rst)
    accept |-> $onehot(keyS))
    else $error("merged key code accepted");
  AST_NONREPEAT: assert property (@(posedge mclk) disable iff (rst)
    (accept && !repeatS && !spaceOk) |=> !armed_r)
    else $error("held key not disarmed");
  AST_ELEM_LEN: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ST_DATA && $changed(elemIdx_r)) |-> $past(tickEnd))
    else $error("element ended off tick");
  AST_LOCK_HOLD: assert property (@(posedge mclk) disable iff (rst)
    (locked_r && !unlockS) |=> locked_r)
    else $error("lock dropped without unlock");
  AST_UNLOCK: assert property (@(posedge mclk) disable iff (rst)
    (unlockS && !lockSet) |=> !locked_r)
    else $error("unlock did not clear lock");
  AST_AUTOLOCK: assert property (@(posedge mclk) disable iff (rst)
    blankLock |=> locked_r)
    else $error("blank character did not lock");
  AST_QUEUED: assert property (@(posedge mclk) disable iff (rst)
    (pending_r && !launch) |=> pending_r && $stable(pendCode_r))
    else $error("queued key lost before launch");

  COV_FRAME: cover property (@(posedge mclk) disable iff (rst)
    stopEnd && !pending_r);
  COV_QUEUED: cover property (@(posedge mclk) disable iff (rst)
    stopEnd && pending_r);
  COV_REPEAT: cover property (@(posedge mclk) disable iff (rst)
    accept && repeatS && !armed_r);
  COV_AUTOLOCK: cover property (@(posedge mclk) disable iff (rst)
    blankLock);
  COV_SPACE_REP: cover property (@(posedge mclk) disable iff (rst)
    accept && spaceOk && !armed_r);
endmodule

`default_nettype wire

// ===== design/kbd_tx_pkg.sv
// Constants for the keyboard start-stop transmitter.
// Assumes a single 125 MHz clock and a plain register port.
package kbd_tx_pkg;
  localparam int          CLK_PERIOD_PS = 8000;
  // Element time of the motor-driven signal generator, in picoseconds
  localparam longint      ELEM_TIME_PS  = 64'd13_470_000_000;
  localparam int          ELEM_CYCLES   = int'(ELEM_TIME_PS / CLK_PERIOD_PS);
  localparam int          CNT_W         = 24;
  localparam int          CODE_W        = 5;
  localparam int          NKEYS         = 32;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;

  // Register offsets
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;

  // Control fields
  localparam int          CTRL_SPREP    = 0;
  localparam int          CTRL_LMODE_LO = 1;
  localparam logic        SPREP_RST     = 1'b1;
  localparam logic [1:0]  LMODE_RST     = 2'h0;
  localparam logic [1:0]  LMODE_OFF     = 2'h0;
  localparam logic [1:0]  LMODE_SINGLE  = 2'h1;
  localparam logic [1:0]  LMODE_DOUBLE  = 2'h2;

  // Status fields
  localparam int          STAT_LOCK     = 0;
  localparam int          STAT_BUSY     = 1;
  localparam int          STAT_PEND     = 2;
  localparam int          STAT_CODE_LO  = 3;

  // Codes: key index equals its code, element 1 in bit 0
  localparam logic [4:0]  SPACE_CODE    = 5'h04;
  localparam logic [4:0]  BLANK_CODE    = 5'h00;
  // Element index from which the keyboard accepts the next key within a frame
  localparam logic [2:0]  READY_ELEM    = 3'h2;
  localparam logic [2:0]  LAST_ELEM     = 3'h4;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_DATA  = 2'b11,
    ST_STOP  = 2'b10
  } txst_e;
endpackage

// ===== tb/rx_printer.sv
// Receiving printer on the far end of the line; decodes each frame.
// Assumes each element lasts BITC mclk cycles and the line idles marking.
`timescale 1ns/1ps
`default_nettype none
module rx_printer #(
  parameter int BITC = 4
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Line in, decoded characters out
  input  wire logic       lineMark,
  output logic      [4:0] code,
  output logic            gotStb,
  output logic            frameErr
);
  logic       busy;
  int         cnt;
  logic [4:0] sh;
  // Mid-element sampling tolerates a cycle or two of launch skew
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy     <= 1'b0;
      cnt      <= 0;
      sh       <= 5'h00;
      code     <= 5'h00;
      gotStb   <= 1'b0;
      frameErr <= 1'b0;
    end else begin
      gotStb <= 1'b0;
      if (!busy) begin
        busy <= !lineMark;
        cnt  <= 1;
      end else begin
        cnt <= cnt + 1;
        if (cnt % BITC == BITC / 2) begin
          if (cnt / BITC == 0) begin
            frameErr <= frameErr | lineMark;
          end else if (cnt / BITC < 6) begin
            sh <= {lineMark, sh[4:1]};
          end else begin
            frameErr <= frameErr | !lineMark;
            code     <= sh;
            gotStb   <= 1'b1;
            busy     <= 1'b0;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the keyboard start-stop transmitter.
// Assumes rx_printer decodes the line at BITC cycles per element.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import kbd_tx_pkg::*;
  localparam int FRAME = 28;
  localparam int BITC  = 4;
  typedef struct {logic [31:0] key; logic [4:0] exp;} row_s;
  logic        mclk, rst, wrStb, rdStb, lineMark, localReturn;
  logic        autoResendKey, entryBlockKey, entryReleaseKey;
  logic        localReturnKey, rxCharStb, rxCharBlank, gotStb, frameErr;
  logic [7:0]  addr;
  logic [31:0] wrData, rdData, codeKeys, rv;
  logic [4:0]  code;
  logic [4:0]  codeLog [8];
  int          stbAt [8];
  int          mismatches, checks, frames, cyc, n, m;
  row_s        rows [6] = '{'{32'h0020_0000, 5'h15}, '{32'h8000_0000, 5'h1F},
    '{32'h0000_0002, 5'h01}, '{32'h0001_0000, 5'h10},
    '{32'h0000_0400, 5'h0A}, '{32'h0000_0001, 5'h00}};

  kbd_start_stop_tx #(.BIT_CYCLES(BITC)) u_kbd_start_stop_tx (
    .mclk(mclk), .rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb),
    .rdStb(rdStb), .rdData(rdData), .codeKeys(codeKeys),
    .autoResendKey(autoResendKey), .entryBlockKey(entryBlockKey),
    .entryReleaseKey(entryReleaseKey), .localReturnKey(localReturnKey),
    .rxCharStb(rxCharStb), .rxCharBlank(rxCharBlank),
    .lineMark(lineMark), .localReturn(localReturn));
  rx_printer #(.BITC(BITC)) u_rx_printer (
    .mclk(mclk), .rst(rst), .lineMark(lineMark), .code(code),
    .gotStb(gotStb), .frameErr(frameErr));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (gotStb === 1'b1) begin
      codeLog[frames % 8] = code;
      stbAt[frames % 8] = cyc;
      frames++;
    end
  end

  task tick(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task test_done;
    $display("Checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr   <= a;
    wrData <= d;
    wrStb  <= 1'b1;
    @(posedge mclk);
    wrStb <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    rdStb <= 1'b1;
    @(posedge mclk);
    rdStb <= 1'b0;
    @(posedge mclk);
    d = rdData;
  endtask
  // Bounded wait: line going to spacing, or first decoded frame
  task waitEv(input bit onLine, input int lim);
    n = 0;
    while ((onLine ? lineMark !== 1'b0 : frames == 0) && n < lim) begin
      tick(1);
      n++;
    end
    if (n >= lim) begin
      chk("wait bound", 0, 1);
      test_done;
    end
  endtask
  task burst(input logic [31:0] k, input logic rep, input int h);
    frames = 0;
    @(posedge mclk);
    codeKeys      <= k;
    autoResendKey <= rep;
    tick(h);
    codeKeys      <= 32'h0;
    autoResendKey <= 1'b0;
    tick(2 * FRAME + 10);
  endtask
  task kbdKey(input bit lock);
    @(posedge mclk);
    entryBlockKey   <= lock;
    entryReleaseKey <= !lock;
    tick(4);
    entryBlockKey   <= 1'b0;
    entryReleaseKey <= 1'b0;
    tick(4);
  endtask
  task rxChar(input logic b);
    @(posedge mclk);
    rxCharBlank <= b;
    tick(2);
    rxCharStb <= 1'b1;
    tick(3);
    rxCharStb <= 1'b0;
    tick(4);
  endtask

  initial begin
    #400000;
    chk("run time", 0, 1);
    test_done;
  end

  initial begin
    {rst, wrStb, rdStb, autoResendKey, entryBlockKey} = 5'h10;
    {entryReleaseKey, localReturnKey, rxCharStb, rxCharBlank} = 4'h0;
    {addr, wrData, codeKeys} = 72'h0;
    {mismatches, checks, frames, cyc} = 128'h0;
    tick(20);
    rst <= 1'b0;
    chk("line at reset", 1, lineMark);
    rd(ADDR_CTRL, rv);
    chk("ctrl reset", 32'({LMODE_RST, SPREP_RST}), rv);
    rd(ADDR_STATUS, rv);
    chk("status reset", 0, rv[2:0]);
    wr(8'h08, 32'hFFFF_FFFF);
    rd(8'h08, rv);
    chk("unmapped", 0, rv);
    $display("Test registers done");
    foreach (rows[i]) begin
      frames = 0;
      @(posedge mclk);
      codeKeys <= rows[i].key;
      waitEv(1'b1, 10);
      chk("latency", 1, n <= 7);
      tick(6);
      codeKeys <= 32'h0;
      waitEv(1'b0, 80);
      tick(4);
      chk("code", rows[i].exp, codeLog[0]);
      chk("idle line", 1, lineMark);
      rd(ADDR_STATUS, rv);
      chk("frozen code", rows[i].exp, rv[STAT_CODE_LO +: CODE_W]);
    end
    $display("Test rows done");
    burst(32'h20, 1'b0, 150);
    chk("held key", 1, frames);
    burst(32'h20, 1'b0, 8);
    chk("rearmed key", 1, frames);
    burst(32'h80, 1'b1, 150);
    chk("repeat count", 1, frames >= 4);
    chk("repeat code", 5'h07, codeLog[1]);
    burst(32'h10, 1'b0, 150);
    chk("space repeat", 1, frames >= 4);
    wr(ADDR_CTRL, 32'h0);
    burst(32'h10, 1'b0, 150);
    chk("space single", 1, frames);
    $display("Test repeat done");
    kbdKey(1'b1);
    rd(ADDR_STATUS, rv);
    chk("locked", 1, rv[STAT_LOCK]);
    burst(32'h40, 1'b0, 10);
    chk("locked frames", 0, frames);
    kbdKey(1'b0);
    burst(32'h40, 1'b0, 10);
    chk("unlocked frames", 1, frames);
    wr(ADDR_CTRL, 32'(LMODE_SINGLE) << CTRL_LMODE_LO);
    rxChar(1'b1);
    rd(ADDR_STATUS, rv);
    chk("single blank", 1, rv[STAT_LOCK]);
    kbdKey(1'b0);
    wr(ADDR_CTRL, 32'(LMODE_DOUBLE) << CTRL_LMODE_LO);
    rxChar(1'b0);
    rxChar(1'b1);
    rd(ADDR_STATUS, rv);
    chk("one of two blanks", 0, rv[STAT_LOCK]);
    rxChar(1'b1);
    rd(ADDR_STATUS, rv);
    chk("double blank", 1, rv[STAT_LOCK]);
    kbdKey(1'b0);
    wr(ADDR_CTRL, 32'h0);
    rxChar(1'b1);
    rxChar(1'b1);
    rd(ADDR_STATUS, rv);
    chk("blank lock off", 0, rv[STAT_LOCK]);
    $display("Test lock done");
    burst(32'h208, 1'b0, 10);
    chk("two keys", 0, frames);
    @(posedge mclk);
    localReturnKey <= 1'b1;
    {n, m} = 64'h0;
    repeat (12) begin
      tick(1);
      n += (localReturn === 1'b1);
      m += (lineMark !== 1'b1);
    end
    localReturnKey <= 1'b0;
    chk("local return", 1, n);
    chk("line quiet", 0, m);
    frames = 0;
    @(posedge mclk);
    codeKeys <= 32'h8;
    tick(14);
    codeKeys <= 32'h0;
    tick(3);
    codeKeys <= 32'h1000_0000;
    tick(6);
    codeKeys <= 32'h0;
    tick(3 * FRAME);
    chk("queued frames", 2, frames);
    chk("first code", 5'h03, codeLog[0]);
    chk("second code", 5'h1C, codeLog[1]);
    chk("frame gap", FRAME, stbAt[1] - stbAt[0]);
    chk("framing", 0, frameErr);
    $display("Test overlap done");
    @(posedge mclk);
    codeKeys <= 32'h2;
    tick(12);
    rst <= 1'b1;
    tick(3);
    chk("line in reset", 1, lineMark);
    rst      <= 1'b0;
    codeKeys <= 32'h0;
    rd(ADDR_CTRL, rv);
    chk("ctrl after reset", 32'({LMODE_RST, SPREP_RST}), rv);
    rd(ADDR_STATUS, rv);
    chk("status after reset", 0, rv);
    tick(1);
    chk("read data cleared", 0, rdData);
    frames = 0;
    @(posedge mclk);
    codeKeys <= 32'h0020_0000;
    tick(8);
    codeKeys <= 32'h0;
    tick(FRAME + 10);
    chk("frames after reset", 1, frames);
    chk("code after reset", 5'h15, codeLog[0]);
    chk("framing after reset", 0, frameErr);
    $display("Test reset done");
    test_done;
  end
endmodule
`default_nettype wire
